// >>> cpu_irq_acceptor.sv
`timescale 1ns/100ps
// ============================================================================
// Stand-in for the CPU side that accepts interrupt vectors.
// ============================================================================
module cpu_irq_acceptor #(
    parameter int ACK_DELAY = 2
) (
    input  wire logic                         hclk,
    input  wire logic                         hresetn,
    input  wire logic                         ack_en,
    input  wire pin_change_irq_pkg::irq_vec_t irq_req,
    output pin_change_irq_pkg::irq_vec_t      irq_taken,
    output logic [7:0]                        ack_count
);
    logic [3:0] wait_cnt;

    // A vector is taken some cycles after its request, as a core finishing an instruction would.
    // Only one vector a time, the external one first, so a stale request is never acknowledged.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_cnt  <= 4'h0;
            irq_taken <= 3'h0;
            ack_count <= 8'h00;
        end else begin
            irq_taken <= 3'h0;
            if (!ack_en || irq_req == 3'h0 || irq_taken != 3'h0) begin
                wait_cnt <= 4'h0;
            end else if (wait_cnt == ACK_DELAY[3:0]) begin
                wait_cnt        <= 4'h0;
                irq_taken.ext   <= irq_req.ext;
                irq_taken.upper <= irq_req.upper & !irq_req.ext;
                irq_taken.lower <= irq_req.lower & !irq_req.ext & !irq_req.upper;
                ack_count       <= ack_count + 8'h01;
            end else begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end
    end
endmodule

// >>> pin_change_ext_irq_flags.sv
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/100ps
// Contract
// - Reserved bits 7 and 3:0 of the flag register and 7:4 of the upper mask read as zero.
// - A configured edge or change on the external pin sets the external flag in bit 6.
// - The external vector is requested only with global enable and its enable set, and with its flag or, in level mode, a low pin.
// - Each of the three flags clears when the CPU takes the matching interrupt routine.
// - Writing a one to a flag bit clears that flag, so software can drop it unserviced.
// - The external flag stays zero while the external pin is set to sense a low level.
// - A change on any enabled upper source pin 11:8 sets the upper flag in bit 5.
// - The upper vector is requested only with its flag, global enable and group enable set.
// - A change on any enabled lower source pin 7:0 sets the lower flag in bit 4.
// - The lower vector is requested only with its flag, global enable and group enable set.
// - An upper pin is a source only when both its mask bit and the upper group enable are set.
// - Changes on an upper pin whose mask bit is clear produce no request.
// - The digital input of a pin is forced on while its mask bit and group enable are both set.
// - Each lower pin is gated by its own bit of a separate lower mask register.
module pin_change_ext_irq_flags (
    input  wire logic                             hclk,
    input  wire logic                             hresetn,
    input  wire logic                             clk_en,
    input  wire logic                             hsel,
    input  wire logic [31:0]                      haddr,
    input  wire logic [1:0]                       htrans,
    input  wire logic                             hwrite,
    input  wire logic [2:0]                       hsize,
    input  wire logic [31:0]                      hwdata,
    input  wire logic                             hready,
    output logic                                  hreadyout,
    output logic                                  hresp,
    output logic [31:0]                           hrdata,
    input  wire logic                             ext_irq_pin,
    input  wire logic [3:0]                       pinchg_src_upper,
    input  wire logic [7:0]                       pinchg_src_lower,
    input  wire logic                             global_irq_en,
    input  wire pin_change_irq_pkg::irq_vec_t     irq_taken,
    input  wire logic [11:0]                      analog_digin_off,
    output pin_change_irq_pkg::irq_vec_t          irq_req,
    output logic                                  irq,
    output logic [11:0]                           digin_en_override_en,
    output logic [11:0]                           digin_en_override_val
);

    // ========================================================================
    // Register decode helpers.
    // ========================================================================
    // Matches a word address against a register index; upper address bits alias.
    function automatic logic idx_hit(input logic [31:0] addr, input logic [7:0] idx);
        idx_hit = (addr[9:2] == idx);
    endfunction

    // ========================================================================
    // State.
    // ========================================================================
    logic [2:0]                      flags;         // ext, upper, lower.
    logic [2:0]                      enables;       // Same layout as flags.
    logic [3:0]                      pinchg_mask_upper;
    logic [7:0]                      pinchg_mask_lower;
    pin_change_irq_pkg::ext_sense_t  ext_sense;
    logic [12:0]                     pin_meta;      // First synchroniser stage.
    logic [12:0]                     pin_sync;      // Second synchroniser stage.
    logic [12:0]                     pin_prev;      // Previous synchronised sample.
    logic                            wr_pend;
    logic [31:0]                     wr_addr;

    // ========================================================================
    // AHB-Lite address phase decode.
    // ========================================================================
    // The slave never inserts wait states, so hreadyout is a constant high.
    logic        addr_valid;
    logic        rd_take;
    logic        wr_take;
    logic [31:0] rd_word;
    logic        sel_flags;
    logic        sel_enable;
    logic        sel_upper;
    logic        sel_lower;
    logic        sel_sense;
    assign addr_valid = hsel && (htrans == pin_change_irq_pkg::HTRANS_NONSEQ) && hready;
    assign rd_take    = clk_en && addr_valid && !hwrite;
    assign wr_take    = clk_en && addr_valid && hwrite;
    assign sel_flags  = idx_hit(haddr, pin_change_irq_pkg::IDX_GENERAL_IRQ_FLAGS);
    assign sel_enable = idx_hit(haddr, pin_change_irq_pkg::IDX_GENERAL_IRQ_MASK_REG);
    assign sel_upper  = idx_hit(haddr, pin_change_irq_pkg::IDX_PINCHG_MASK_UPPER);
    assign sel_lower  = idx_hit(haddr, pin_change_irq_pkg::IDX_PINCHG_MASK_LOWER);
    assign sel_sense  = idx_hit(haddr, pin_change_irq_pkg::IDX_EXT_SENSE_CFG);
    assign hreadyout  = 1'b1;
    assign hresp      = pin_change_irq_pkg::HRESP_OKAY;

    // Read mux; unused and reserved bits are zero, unmapped words read zero.
    assign rd_word = sel_flags  ? {24'h000000, 1'b0, flags, 4'h0} :
                     sel_enable ? {24'h000000, 1'b0, enables, 4'h0} :
                     sel_upper  ? {28'h0000000, pinchg_mask_upper} :
                     sel_lower  ? {24'h000000, pinchg_mask_lower} :
                     sel_sense  ? {30'h00000000, ext_sense} :
                     pin_change_irq_pkg::RDATA_UNMAPPED;

    // Read data is captured at the address phase edge and held into the data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= pin_change_irq_pkg::RDATA_UNMAPPED;
        end else if (rd_take) begin
            hrdata <= rd_word;
        end
    end

    // The write address is held so the write lands when hwdata is valid.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 32'h0000_0000;
        end else if (clk_en) begin
            wr_pend <= wr_take;
            wr_addr <= wr_take ? haddr : wr_addr;
        end
    end

    // ========================================================================
    // Data phase write strobes.
    // ========================================================================
    logic wr_flags;
    logic wr_enable;
    logic wr_upper;
    logic wr_lower;
    logic wr_sense;
    assign wr_flags  = clk_en && wr_pend && idx_hit(wr_addr, pin_change_irq_pkg::IDX_GENERAL_IRQ_FLAGS);
    assign wr_enable = clk_en && wr_pend && idx_hit(wr_addr, pin_change_irq_pkg::IDX_GENERAL_IRQ_MASK_REG);
    assign wr_upper  = clk_en && wr_pend && idx_hit(wr_addr, pin_change_irq_pkg::IDX_PINCHG_MASK_UPPER);
    assign wr_lower  = clk_en && wr_pend && idx_hit(wr_addr, pin_change_irq_pkg::IDX_PINCHG_MASK_LOWER);
    assign wr_sense  = clk_en && wr_pend && idx_hit(wr_addr, pin_change_irq_pkg::IDX_EXT_SENSE_CFG);

    // Configuration registers; only the documented widths are stored.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enables           <= pin_change_irq_pkg::RST_GENERAL_IRQ_MASK_REG[6:4];
            pinchg_mask_upper <= pin_change_irq_pkg::RST_PINCHG_MASK_UPPER;
            pinchg_mask_lower <= pin_change_irq_pkg::RST_PINCHG_MASK_LOWER;
            ext_sense         <= pin_change_irq_pkg::ext_sense_t'(pin_change_irq_pkg::RST_EXT_SENSE_CFG);
        end else begin
            if (wr_enable) enables <= hwdata[6:4];
            if (wr_upper) pinchg_mask_upper <= hwdata[3:0];
            if (wr_lower) pinchg_mask_lower <= hwdata[7:0];
            if (wr_sense) ext_sense <= pin_change_irq_pkg::ext_sense_t'(hwdata[1:0]);
        end
    end

    // ========================================================================
    // Pin synchronisers and change detection.
    // ========================================================================
    // Pins are asynchronous, so two flops come before any logic looks at them.
    logic [12:0] pin_raw;
    logic [12:0] pin_change;
    assign pin_raw    = {ext_irq_pin, pinchg_src_upper, pinchg_src_lower};
    assign pin_change = pin_sync ^ pin_prev;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta <= 13'h0000;
            pin_sync <= 13'h0000;
            pin_prev <= 13'h0000;
        end else if (clk_en) begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // ========================================================================
    // Event qualification.
    // ========================================================================
    logic        ext_now;
    logic        ext_was;
    logic        ext_event;
    logic [3:0]  upper_armed;
    logic [7:0]  lower_armed;
    logic        upper_event;
    logic        lower_event;
    assign ext_now = pin_sync[12];
    assign ext_was = pin_prev[12];

    // Level sensing never raises an event, which also keeps the flag at zero.
    assign ext_event = clk_en && (
                       (ext_sense == pin_change_irq_pkg::SENSE_ANY_EDGE  && ext_now != ext_was) ||
                       (ext_sense == pin_change_irq_pkg::SENSE_FALL_EDGE && !ext_now && ext_was) ||
                       (ext_sense == pin_change_irq_pkg::SENSE_RISE_EDGE && ext_now && !ext_was));

    // A pin counts only when both its mask bit and its group enable are set.
    assign upper_armed = pinchg_mask_upper & {4{enables[1]}};
    assign lower_armed = pinchg_mask_lower & {8{enables[0]}};
    assign upper_event = clk_en && |(pin_change[11:8] & upper_armed);
    assign lower_event = clk_en && |(pin_change[7:0] & lower_armed);

    // ========================================================================
    // Sticky flags.
    // ========================================================================
    // A set in the same cycle as a clear wins, so no event is ever dropped.
    logic [2:0] flag_set;
    logic [2:0] flag_clr;
    logic [2:0] next_flags;
    logic       ext_level_mode;
    assign ext_level_mode = (ext_sense == pin_change_irq_pkg::SENSE_LOW_LEVEL);
    assign flag_set = {ext_event, upper_event, lower_event};
    assign flag_clr = ({3{wr_flags}} & hwdata[6:4])
                    | ({3{clk_en}} & {irq_taken.ext, irq_taken.upper, irq_taken.lower});
    assign next_flags = {(flags[2] & !flag_clr[2] & !ext_level_mode) | flag_set[2],
                         (flags[1:0] & ~flag_clr[1:0]) | flag_set[1:0]};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags <= pin_change_irq_pkg::RST_GENERAL_IRQ_FLAGS[6:4];
        end else if (clk_en) begin
            flags <= next_flags;
        end
    end

    // ========================================================================
    // Vector requests to the CPU.
    // ========================================================================
    // In level mode the request follows the low pin directly instead of a flag.
    assign irq_req.ext   = global_irq_en && enables[2] &&
                           (flags[2] || (ext_level_mode && !ext_now));
    assign irq_req.upper = global_irq_en && enables[1] && flags[1];
    assign irq_req.lower = global_irq_en && enables[0] && flags[0];
    assign irq           = |irq_req;

    // ========================================================================
    // Digital input enable override.
    // ========================================================================
    // Sensing needs the input buffer even when an analog user switched it off.
    logic [11:0] pinchg_armed;
    assign pinchg_armed          = {upper_armed, lower_armed};
    assign digin_en_override_en  = pinchg_armed | analog_digin_off;
    assign digin_en_override_val = pinchg_armed;

    // ========================================================================
    // Assertions.
    // ========================================================================
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    flag_rsvd_zero_a: assert property (rd_take && sel_flags |=>
        hrdata[7] == 1'b0 && hrdata[3:0] == 4'h0)
        else $error("Reserved flag bits read nonzero.");
    upper_rsvd_zero_a: assert property (rd_take && sel_upper |=>
        hrdata[7:4] == 4'h0)
        else $error("Reserved upper mask bits read nonzero.");
    ext_flag_set_a: assert property (ext_event |=> flags[2])
        else $error("External event did not set its flag.");
    ext_vector_gate_a: assert property (irq_req.ext && !ext_level_mode |->
        flags[2] && global_irq_en && enables[2])
        else $error("External vector without flag and enables.");
    taken_clear_a: assert property (clk_en && irq_taken.upper && !upper_event |=>
        !flags[1])
        else $error("Upper flag survived its routine.");
    write_one_clear_a: assert property (wr_flags && hwdata[4] && !lower_event |=>
        !flags[0])
        else $error("Lower flag survived a write of one.");
    set_beats_clear_a: assert property (wr_flags && hwdata[4] && lower_event |=>
        flags[0])
        else $error("Clear beat a same-cycle set.");
    level_hold_a: assert property (ext_level_mode && $past(ext_level_mode) |->
        !flags[2])
        else $error("External flag set in level mode.");
    upper_set_a: assert property (upper_event |=> flags[1])
        else $error("Upper change did not set its flag.");
    upper_vector_a: assert property (irq_req.upper |->
        flags[1] && global_irq_en && enables[1])
        else $error("Upper vector without flag and enables.");
    lower_set_a: assert property (lower_event |=> flags[0])
        else $error("Lower change did not set its flag.");
    lower_vector_a: assert property (irq_req.lower |->
        flags[0] && global_irq_en && enables[0])
        else $error("Lower vector without flag and enables.");
    masked_pin_a: assert property (upper_event |-> enables[1] &&
        (pin_change[11:8] & pinchg_mask_upper) != 4'h0)
        else $error("Upper request from an unarmed pin.");
    masked_quiet_a: assert property (clk_en && !flags[1] &&
        (pin_change[11:8] & pinchg_mask_upper) == 4'h0 && !upper_event |=> !flags[1])
        else $error("Masked upper pin set the flag.");
    override_on_a: assert property (pinchg_mask_lower[0] && enables[0] |->
        digin_en_override_en[0] && digin_en_override_val[0])
        else $error("Input buffer not forced for armed pin.");
    upper_override_a: assert property (pinchg_mask_upper[1] && enables[1] |->
        digin_en_override_en[9] && digin_en_override_val[9])
        else $error("Input buffer not forced for armed upper pin.");
    lower_gate_a: assert property (lower_event |-> enables[0] &&
        (pin_change[7:0] & pinchg_mask_lower) != 8'h00)
        else $error("Lower request from an unarmed pin.");
    // A flag left over from edge mode may still request for one cycle after the switch.
    level_vector_a: assert property (irq_req.ext && ext_level_mode && !flags[2] |->
        !ext_now && global_irq_en && enables[2])
        else $error("Level vector without a low pin and enables.");
    sync_delay_a: assert property (clk_en && !ext_level_mode &&
        ext_sense == pin_change_irq_pkg::SENSE_ANY_EDGE && $changed(pin_sync[12]) |-> ext_event)
        else $error("Synchronised change missed.");

    ext_rise_c:  cover property (ext_event ##1 irq_req.ext ##[1:20] irq_taken.ext);
    upper_clr_c: cover property (upper_event ##[1:20] wr_flags && hwdata[5]);
    lower_irq_c: cover property (lower_event ##1 irq);

    // A vector taken by the CPU and a request held by a low level on the external pin.
    upper_taken_c: cover property (irq_req.upper ##[1:10] irq_taken.upper);
    level_req_c:   cover property (ext_level_mode && irq_req.ext);

endmodule

// >>> pin_change_irq_pkg.sv
// ============================================================================
// Shared constants and types for the pin-change and external interrupt block.
// ============================================================================
package pin_change_irq_pkg;

    // ========================================================================
    // Register indices; the byte address is four times the index.
    // ========================================================================
    localparam logic [7:0] IDX_GENERAL_IRQ_FLAGS    = 8'h3A;
    localparam logic [7:0] IDX_GENERAL_IRQ_MASK_REG = 8'h3B;
    localparam logic [7:0] IDX_PINCHG_MASK_UPPER    = 8'h3C;
    localparam logic [7:0] IDX_PINCHG_MASK_LOWER    = 8'h3D;
    localparam logic [7:0] IDX_EXT_SENSE_CFG        = 8'h3E;

    // ========================================================================
    // Field positions shared by the flag register and the enable register.
    // ========================================================================
    localparam int BIT_EXT   = 6;
    localparam int BIT_UPPER = 5;
    localparam int BIT_LOWER = 4;
    localparam logic [7:0] FLAGS_USED_MASK = 8'h70;
    localparam logic [7:0] UPPER_USED_MASK = 8'h0F;
    localparam logic [7:0] SENSE_USED_MASK = 8'h03;

    // ========================================================================
    // Widths and values after reset.
    // ========================================================================
    localparam int UPPER_PINS = 4;
    localparam int LOWER_PINS = 8;
    localparam int ALL_PINS   = 12;
    localparam logic [7:0] RST_GENERAL_IRQ_FLAGS    = 8'h00;
    localparam logic [7:0] RST_GENERAL_IRQ_MASK_REG = 8'h00;
    localparam logic [3:0] RST_PINCHG_MASK_UPPER    = 4'h0;
    localparam logic [7:0] RST_PINCHG_MASK_LOWER    = 8'h00;
    localparam logic [1:0] RST_EXT_SENSE_CFG        = 2'h0;
    localparam logic [31:0] RDATA_UNMAPPED          = 32'h0000_0000;

    // ========================================================================
    // AHB-Lite encodings.
    // ========================================================================
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

    // ========================================================================
    // Sense modes of the external interrupt pin.
    // ========================================================================
    typedef enum logic [1:0] {
        SENSE_LOW_LEVEL = 2'h0,
        SENSE_ANY_EDGE  = 2'h1,
        SENSE_FALL_EDGE = 2'h2,
        SENSE_RISE_EDGE = 2'h3
    } ext_sense_t;

    // One bit for each of the three interrupt vectors.
    typedef struct packed {
        logic ext;
        logic upper;
        logic lower;
    } irq_vec_t;

endpackage

// >>> testbench.sv
`timescale 1ns/100ps
module testbench;
    localparam logic [7:0] FLG = pin_change_irq_pkg::IDX_GENERAL_IRQ_FLAGS;
    localparam logic [7:0] ENA = pin_change_irq_pkg::IDX_GENERAL_IRQ_MASK_REG;
    localparam logic [7:0] UPM = pin_change_irq_pkg::IDX_PINCHG_MASK_UPPER;
    localparam logic [7:0] LOM = pin_change_irq_pkg::IDX_PINCHG_MASK_LOWER;
    localparam logic [7:0] SNS = pin_change_irq_pkg::IDX_EXT_SENSE_CFG;
    logic hclk, hresetn, clk_en, hsel, hwrite, hreadyout, hresp, irq, ext_irq_pin;
    logic global_irq_en, ack_en;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] pinchg_src_upper;
    logic [7:0] pinchg_src_lower, ack_count;
    logic [11:0] analog_digin_off, ovr_en, ovr_val;
    pin_change_irq_pkg::irq_vec_t irq_req, irq_taken;
    int failures, n_compared;

    pin_change_ext_irq_flags DUT (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .ext_irq_pin(ext_irq_pin), .pinchg_src_upper(pinchg_src_upper),
        .pinchg_src_lower(pinchg_src_lower), .global_irq_en(global_irq_en),
        .irq_taken(irq_taken), .analog_digin_off(analog_digin_off), .irq_req(irq_req),
        .irq(irq), .digin_en_override_en(ovr_en), .digin_en_override_val(ovr_val));
    cpu_irq_acceptor cpu (.hclk(hclk), .hresetn(hresetn), .ack_en(ack_en),
        .irq_req(irq_req), .irq_taken(irq_taken), .ack_count(ack_count));

    // ========================================================================
    // Clock, watchdog and shared tasks.
    // ========================================================================
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    // The tests need under 2000 cycles; a hung handshake is cut off well after that.
    initial begin
        repeat (20000) @(posedge hclk);
        failures++;
        wrap_up();
    end
    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // Waits for hready at a rising edge under a bound; the slave never stalls, but none assumed.
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready_ok() == 1'b0 && n < 50);
        // A stalled slave ends the run at once rather than skewing every later check.
        if (n >= 50) begin
            failures++;
            wrap_up();
        end
    endtask
    function automatic logic hready_ok();
        return hreadyout === 1'b1;
    endfunction
    task automatic ahb_access(input logic [7:0] idx, input logic wr, input logic [31:0] d);
        @(posedge hclk);
        htrans <= pin_change_irq_pkg::HTRANS_NONSEQ;
        haddr  <= {22'h000000, idx, 2'b00};
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
        check({31'h0, hresp}, {31'h0, pin_change_irq_pkg::HRESP_OKAY});
    endtask
    task automatic expect_reg(input logic [7:0] idx, input logic [31:0] exp);
        ahb_access(idx, 1'b0, 32'h0000_0000);
        check(rd, exp);
    endtask
    // Five cycles cover the two-flop synchroniser, the compare and one cycle of async slack.
    task automatic settle();
        repeat (5) @(posedge hclk);
    endtask
    task automatic expect_out(input logic [2:0] req, input logic [11:0] val);
        @(negedge hclk);
        check({29'h0, irq_req}, {29'h0, req});
        check({31'h0, irq}, {31'h0, |req});
        check({20'h0, ovr_val}, {20'h0, val});
        @(posedge hclk);
    endtask

    // ========================================================================
    // Test sequence.
    // ========================================================================
    initial begin
        static logic [1:0] modes [3] = '{2'h1, 2'h2, 2'h3};
        static logic rise_hit [3] = '{1'b1, 1'b0, 1'b1};
        static logic fall_hit [3] = '{1'b1, 1'b1, 1'b0};
        {hresetn, hwrite, ext_irq_pin, global_irq_en, ack_en} = 5'h00;
        {clk_en, hsel} = 2'h3;
        {haddr, hwdata} = 64'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        {pinchg_src_upper, pinchg_src_lower, analog_digin_off} = 24'h000000;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        expect_reg(FLG, 32'h0000_0000);
        expect_reg(ENA, 32'h0000_0000);
        expect_reg(LOM, 32'h0000_0000);
        ahb_access(UPM, 1'b1, 32'hFFFF_FFFF);
        expect_reg(UPM, 32'h0000_000F);
        ahb_access(FLG, 1'b1, 32'hFFFF_FFFF);
        expect_reg(FLG, 32'h0000_0000);
        expect_reg(8'h00, pin_change_irq_pkg::RDATA_UNMAPPED);
        $display("test registers done");
        // Lower group: only the masked pin counts, and the vector needs the global enable.
        ahb_access(UPM, 1'b1, 32'h0000_0002);
        ahb_access(LOM, 1'b1, 32'h0000_0001);
        ahb_access(ENA, 1'b1, 32'h0000_0010);
        pinchg_src_lower <= 8'h02;
        settle();
        expect_reg(FLG, 32'h0000_0000);
        pinchg_src_lower <= 8'h03;
        settle();
        expect_reg(FLG, 32'h0000_0010);
        expect_out(3'h0, 12'h001);
        global_irq_en <= 1'b1;
        expect_out(3'h1, 12'h001);
        ahb_access(FLG, 1'b1, 32'h0000_0010);
        expect_reg(FLG, 32'h0000_0000);
        $display("test lower group done");
        // Upper group: disabled group, unmasked pin, then the masked pin with CPU acceptance.
        global_irq_en <= 1'b0;
        analog_digin_off <= 12'h800;
        pinchg_src_upper <= 4'h2;
        settle();
        expect_reg(FLG, 32'h0000_0000);
        check({20'h0, ovr_en}, 32'h0000_0801);
        ahb_access(ENA, 1'b1, 32'h0000_0020);
        pinchg_src_upper <= 4'h3;
        settle();
        expect_reg(FLG, 32'h0000_0000);
        pinchg_src_upper <= 4'h1;
        settle();
        expect_reg(FLG, 32'h0000_0020);
        expect_out(3'h0, 12'h200);
        global_irq_en <= 1'b1;
        ack_en <= 1'b1;
        repeat (8) @(posedge hclk);
        expect_reg(FLG, 32'h0000_0000);
        check({24'h0, ack_count}, 32'h0000_0001);
        $display("test upper group done");
        // External pin: each edge mode against both edges, then level mode.
        ack_en <= 1'b0;
        ahb_access(ENA, 1'b1, 32'h0000_0040);
        for (int i = 0; i < 3; i++) begin
            ahb_access(SNS, 1'b1, {30'h0, modes[i]});
            ahb_access(FLG, 1'b1, 32'h0000_0040);
            ext_irq_pin <= 1'b1;
            settle();
            expect_reg(FLG, {25'h0, rise_hit[i], 6'h00});
            ahb_access(FLG, 1'b1, 32'h0000_0040);
            ext_irq_pin <= 1'b0;
            settle();
            expect_reg(FLG, {25'h0, fall_hit[i], 6'h00});
        end
        ext_irq_pin <= 1'b1;
        settle();
        expect_out(3'h4, 12'h000);
        ahb_access(SNS, 1'b1, 32'h0000_0000);
        expect_reg(FLG, 32'h0000_0000);
        ext_irq_pin <= 1'b0;
        settle();
        expect_reg(FLG, 32'h0000_0000);
        expect_out(3'h4, 12'h000);
        global_irq_en <= 1'b0;
        expect_out(3'h0, 12'h000);
        $display("test external pin done");
        wrap_up();
    end
endmodule
